// >>> design/hic_cfg.svh
`ifndef HIC_CFG_SVH
`define HIC_CFG_SVH
`define HIC_NSRC 8
`define HIC_FERR_W 16
`define HIC_OFF_HOST_MODE 4'h0
`define HIC_OFF_STATUS 4'h8
`define HIC_OFF_RAW 4'h9
`define HIC_OFF_MASK 4'hA
`define HIC_OFF_TRIG 4'hB
`define HIC_MASK_RST 8'h00
`define HIC_TRIG_RST 8'h00
`define HIC_MODE_RST 2'h0
`define HIC_ZERO8 8'h00
`define HIC_MODE_RD_BIT 0
`define HIC_MODE_WR_BIT 1
`endif

// >>> design/hic_pkg.sv
`default_nettype none
`include "hic_cfg.svh"
package hic_pkg;
    // Bit 0 is the least significant member (last in the list)
    typedef struct packed {
        logic watchdog_trip;
        logic compare_out_b;
        logic compare_out_a;
        logic host_char_request;
        logic tracking_warning;
        logic fatal_tracking_fault;
        logic program_line_request;
        logic group_settled;
    } hic_src_t;
    typedef struct packed {
        logic loop_closed;
        logic cmd_vel_zero;
        logic move_timer_idle;
        logic [`HIC_FERR_W-1:0] ferr_mag;
        logic [`HIC_FERR_W-1:0] settle_band_limit;
        logic [`HIC_FERR_W-1:0] fatal_error_limit;
        logic [`HIC_FERR_W-1:0] warning_error_limit;
    } hic_axis_t;
    typedef struct packed {
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } hic_host_bus_t;
    typedef struct packed {
        logic [`HIC_NSRC-1:0] meta;
        logic [`HIC_NSRC-1:0] level;
        logic [`HIC_NSRC-1:0] prev;
    } hic_sync_state_t;
    typedef struct packed {
        logic stage;
        logic strobe;
        logic out;
        logic pulse;
    } hic_cmp_state_t;
    typedef struct packed {
        logic [7:0] pending;
        logic [7:0] mask;
        logic [7:0] trig;
        logic [1:0] host_mode;
        logic [7:0] rdata;
        logic [8:0] settle_cnt;
        hic_src_t src;
    } hic_main_state_t;
endpackage : hic_pkg
`default_nettype wire

// >>> design/hic_src_sync.sv
`default_nettype none
`include "hic_cfg.svh"
module hic_src_sync (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [`HIC_NSRC-1:0] src_i,
    output logic [`HIC_NSRC-1:0] level_o,
    output logic [`HIC_NSRC-1:0] rise_o
);
    hic_pkg::hic_sync_state_t st;
    hic_pkg::hic_sync_state_t next_st;
    always_comb begin
        next_st = st;
        next_st.meta = src_i;
        next_st.level = st.meta;
        next_st.prev = st.level;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign level_o = st.level;
    // Low-to-high between successive stable samples
    genvar i;
    generate
        for (i = 0; i < `HIC_NSRC; i++) begin : g_edge
            assign rise_o[i] = st.level[i] & ~st.prev[i]; // RULE23
        end
    endgenerate
endmodule : hic_src_sync
`default_nettype wire

// >>> design/hic_cmp_direct.sv
`default_nettype none
module hic_cmp_direct (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic fw_wr_i,
    input wire logic fw_stage_i,
    input wire logic fw_strobe_i,
    input wire logic match_toggle_i,
    input wire logic auto_pulse_i,
    output logic compare_o
);
    hic_pkg::hic_cmp_state_t st;
    hic_pkg::hic_cmp_state_t next_st;
    always_comb begin
        next_st = st;
        next_st.pulse = auto_pulse_i;
        if (fw_wr_i) begin
            next_st.stage = fw_stage_i;
        end
        // Strobe lives one cycle only, so firmware never has to clear it
        next_st.strobe = fw_wr_i & fw_strobe_i; // RULE17
        if (st.strobe) begin
            next_st.out = st.stage; // RULE17
        end else begin
            next_st.out = st.out ^ match_toggle_i;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign compare_o = st.out | st.pulse;
endmodule : hic_cmp_direct
`default_nettype wire

// >>> design/hic_ctrl.sv
// Summary of operation
// RULE1: Status read returns eight bits, one per source, 1 means pending.
// RULE2: A source can only become pending while its mask bit allows it.
// RULE3: Any write to status clears all edge-triggered pending bits.
// RULE4: Raw level read returns present level of all eight sources.
// RULE5: Mask bit 1 enables a source, 0 blocks it.
// RULE6: Mask register reads back without disturbing it.
// RULE7: Trigger bit 1 selects level, 0 selects edge triggering.
// RULE8: All sources are edge triggered after reset.
// RULE9: Edge source re-raises only after going low then high again.
// RULE10: Level source still high after a clear re-asserts at once.
// RULE11: Settled needs all axes quiet for count plus one scans.
// RULE12: Line request asserts when open buffer can take another line.
// RULE13: Fatal fault asserts when any axis passes its fatal limit.
// RULE14: Warning asserts when any axis passes its warning limit.
// RULE15: Host char request asserts when ready to pass a character.
// RULE16: Base write selects off, read-ready, write-ready or both.
// RULE17: Compare outputs take staged value on a self-clearing strobe.
// RULE18: With both ASCII options set, pulse compare A per response line.
// RULE19: Firmware leaves compare A alone while ASCII interrupts run.
// RULE20: Watchdog source asserts when the watchdog trips.
// RULE21: Status bit order fixed from settled at 0 to watchdog at 7.
// RULE22: Interrupt request asserts whenever any pending bit is set.
// RULE23: Sources are synchronised and edges found from successive samples.
`default_nettype none
`include "hic_cfg.svh"
module hic_ctrl #(
    parameter int NUM_AXES = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire hic_pkg::hic_host_bus_t host_i,
    output logic [7:0] host_rdata_o,
    output logic host_irq_o,
    input wire hic_pkg::hic_axis_t axes_i [NUM_AXES],
    input wire logic scan_tick_i,
    input wire logic [7:0] settle_scan_count_i,
    input wire logic buffer_open_i,
    input wire logic buffer_is_rotary_i,
    input wire logic [15:0] buffer_free_i,
    input wire logic [15:0] fixed_buffer_threshold_i,
    input wire logic [15:0] rotary_ready_threshold_i,
    input wire logic [15:0] rotary_full_threshold_i,
    input wire logic host_read_ready_i,
    input wire logic host_write_ready_i,
    input wire logic fw_cmp_a_wr_i,
    input wire logic compare_a_stage_value_i,
    input wire logic compare_a_write_strobe_i,
    input wire logic fw_cmp_b_wr_i,
    input wire logic compare_b_stage_value_i,
    input wire logic compare_b_write_strobe_i,
    input wire logic match_toggle_a_i,
    input wire logic match_toggle_b_i,
    input wire logic ascii_shared_mem_enable_i,
    input wire logic ascii_shared_mem_irq_enable_i,
    input wire logic response_loaded_i,
    input wire logic watchdog_trip_i
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    hic_pkg::hic_main_state_t st;
    hic_pkg::hic_main_state_t next_st;
    hic_pkg::hic_src_t src_now;
    logic [7:0] lvl;
    logic [7:0] rise;
    logic cmp_a;
    logic cmp_b;
    logic auto_ascii;
    logic [NUM_AXES-1:0] axis_quiet;
    logic [NUM_AXES-1:0] axis_fatal;
    logic [NUM_AXES-1:0] axis_warn;
    logic all_quiet;
    logic wr_status;
    logic wr_mask;
    logic wr_trig;
    logic wr_mode;
    logic rotary_ok;
    logic fixed_ok;

    // ----------------------------------------
    // Per-axis conditions
    // ----------------------------------------
    genvar a;
    generate
        for (a = 0; a < NUM_AXES; a++) begin : g_axis
            assign axis_quiet[a] = axes_i[a].loop_closed & axes_i[a].cmd_vel_zero
                & axes_i[a].move_timer_idle
                & (axes_i[a].ferr_mag < axes_i[a].settle_band_limit); // RULE11
            assign axis_fatal[a] =
                axes_i[a].ferr_mag > axes_i[a].fatal_error_limit; // RULE13
            assign axis_warn[a] =
                axes_i[a].ferr_mag > axes_i[a].warning_error_limit; // RULE14
        end
    endgenerate
    assign all_quiet = &axis_quiet;

    // ----------------------------------------
    // Buffer readiness
    // ----------------------------------------
    // Rotary buffer needs room above the full mark as well as the ready mark
    assign rotary_ok = (buffer_free_i >= rotary_ready_threshold_i)
        & (buffer_free_i > rotary_full_threshold_i);
    assign fixed_ok = buffer_free_i >= fixed_buffer_threshold_i;

    // ----------------------------------------
    // Compare outputs
    // ----------------------------------------
    assign auto_ascii = ascii_shared_mem_enable_i & ascii_shared_mem_irq_enable_i;

    hic_cmp_direct u_cmp_a (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        // Direct writes are locked out so they cannot fake a response
        .fw_wr_i(fw_cmp_a_wr_i & ~auto_ascii), // RULE19
        .fw_stage_i(compare_a_stage_value_i),
        .fw_strobe_i(compare_a_write_strobe_i),
        .match_toggle_i(match_toggle_a_i & ~auto_ascii),
        .auto_pulse_i(auto_ascii & response_loaded_i), // RULE18
        .compare_o(cmp_a)
    );

    hic_cmp_direct u_cmp_b (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .fw_wr_i(fw_cmp_b_wr_i),
        .fw_stage_i(compare_b_stage_value_i),
        .fw_strobe_i(compare_b_write_strobe_i),
        .match_toggle_i(match_toggle_b_i),
        .auto_pulse_i(1'b0),
        .compare_o(cmp_b)
    );

    // ----------------------------------------
    // Source vector and synchroniser
    // ----------------------------------------
    always_comb begin
        src_now = st.src; // RULE21
        src_now.compare_out_a = cmp_a;
        src_now.compare_out_b = cmp_b;
        src_now.watchdog_trip = watchdog_trip_i; // RULE20
    end

    hic_src_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .src_i(src_now),
        .level_o(lvl),
        .rise_o(rise)
    );

    // ----------------------------------------
    // Host bus decode
    // ----------------------------------------
    assign wr_status = host_i.wr & (host_i.addr == `HIC_OFF_STATUS);
    assign wr_mask = host_i.wr & (host_i.addr == `HIC_OFF_MASK);
    assign wr_trig = host_i.wr & (host_i.addr == `HIC_OFF_TRIG);
    assign wr_mode = host_i.wr & (host_i.addr == `HIC_OFF_HOST_MODE);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        if (wr_mask) begin
            next_st.mask = host_i.wdata; // RULE5
        end
        if (wr_trig) begin
            next_st.trig = host_i.wdata; // RULE7
        end
        if (wr_mode) begin
            next_st.host_mode = host_i.wdata[1:0]; // RULE16
        end
        // Edge bits: clear on status write, but a fresh edge wins the same cycle
        next_st.pending = st.pending & ~st.trig;
        if (wr_status) begin
            next_st.pending = `HIC_ZERO8; // RULE3
        end
        next_st.pending = next_st.pending | (rise & ~next_st.trig); // RULE9
        // Level bits follow the input, so a clear cannot hold them off
        next_st.pending = next_st.pending | (lvl & next_st.trig); // RULE10
        next_st.pending = next_st.pending & next_st.mask; // RULE2
        // Scan counter saturates; any disturbance restarts it
        if (!all_quiet) begin
            next_st.settle_cnt = '0;
        end else if (scan_tick_i && (st.settle_cnt != '1)) begin
            next_st.settle_cnt = st.settle_cnt + 9'h001;
        end
        next_st.src.group_settled = all_quiet
            & (next_st.settle_cnt > {1'b0, settle_scan_count_i}); // RULE11
        next_st.src.program_line_request = buffer_open_i
            & (buffer_is_rotary_i ? rotary_ok : fixed_ok); // RULE12
        next_st.src.fatal_tracking_fault = |axis_fatal; // RULE13
        next_st.src.tracking_warning = |axis_warn; // RULE14
        next_st.src.host_char_request =
            (st.host_mode[`HIC_MODE_RD_BIT] & host_read_ready_i)
            | (st.host_mode[`HIC_MODE_WR_BIT] & host_write_ready_i); // RULE15
        next_st.src.compare_out_a = 1'b0;
        next_st.src.compare_out_b = 1'b0;
        next_st.src.watchdog_trip = 1'b0;
        if (host_i.rd) begin
            unique case (host_i.addr)
                `HIC_OFF_STATUS: next_st.rdata = st.pending; // RULE1
                `HIC_OFF_RAW: next_st.rdata = lvl; // RULE4
                `HIC_OFF_MASK: next_st.rdata = st.mask; // RULE6
                `HIC_OFF_TRIG: next_st.rdata = st.trig;
                default: next_st.rdata = `HIC_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
            st.mask <= `HIC_MASK_RST;
            st.trig <= `HIC_TRIG_RST; // RULE8
            st.host_mode <= `HIC_MODE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign host_rdata_o = st.rdata;
    assign host_irq_o = |st.pending; // RULE22

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    mask_gates_pending_a: assert property ( // RULE2
        (st.pending & ~st.mask) == `HIC_ZERO8
    ) else $error("pending bit set while masked");

    status_clear_edge_a: assert property ( // RULE3
        wr_status && !wr_trig && !wr_mask && st.trig == `HIC_ZERO8
            && rise == `HIC_ZERO8
        |=> st.pending == `HIC_ZERO8
    ) else $error("status write left an edge bit pending");

    edge_sets_pending_a: assert property ( // RULE9
        !host_i.wr && ((rise & st.mask & ~st.trig) != `HIC_ZERO8)
        |=> (st.pending & $past(rise & st.mask & ~st.trig))
            == $past(rise & st.mask & ~st.trig)
    ) else $error("unmasked edge not latched");

    level_reassert_a: assert property ( // RULE10
        !wr_mask && !wr_trig
        |=> (st.pending & $past(lvl & st.mask & st.trig))
            == $past(lvl & st.mask & st.trig)
    ) else $error("level source not pending");

    raw_read_level_a: assert property ( // RULE4
        host_i.rd && host_i.addr == `HIC_OFF_RAW |=> host_rdata_o == $past(lvl)
    ) else $error("raw read mismatch");

    mask_read_stable_a: assert property ( // RULE6
        host_i.rd && !host_i.wr && host_i.addr == `HIC_OFF_MASK
        |=> host_rdata_o == $past(st.mask) && $stable(st.mask)
    ) else $error("mask read wrong or disturbed");

    irq_follows_pending_a: assert property ( // RULE22
        $rose(host_irq_o) |-> $past(st.pending) == `HIC_ZERO8 && st.pending != `HIC_ZERO8
    ) else $error("interrupt rose without pending bit");

    settle_drops_a: assert property ( // RULE11
        !all_quiet |=> !st.src.group_settled ##2 !lvl[0]
    ) else $error("settled held while an axis moves");

    host_mode_sel_a: assert property ( // RULE16
        ##1 st.src.host_char_request ==
            (($past(st.host_mode[`HIC_MODE_RD_BIT]) & $past(host_read_ready_i))
            | ($past(st.host_mode[`HIC_MODE_WR_BIT]) & $past(host_write_ready_i)))
    ) else $error("host char request ignores mode");

    // ----------------------------------------
    // Register and source checks
    // ----------------------------------------
    status_read_a: assert property ( // RULE1
        host_i.rd && host_i.addr == `HIC_OFF_STATUS |=> host_rdata_o == $past(st.pending)
    ) else $error("status read mismatch");

    trig_read_a: assert property ( // RULE7
        host_i.rd && host_i.addr == `HIC_OFF_TRIG |=> host_rdata_o == $past(st.trig)
    ) else $error("trigger read mismatch");

    mask_write_a: assert property ( // RULE5
        wr_mask |=> st.mask == $past(host_i.wdata)
    ) else $error("mask write not taken");

    trig_write_a: assert property ( // RULE7
        wr_trig |=> st.trig == $past(host_i.wdata)
    ) else $error("trigger write not taken");

    mode_write_a: assert property ( // RULE16
        wr_mode |=> st.host_mode == $past(host_i.wdata[`HIC_MODE_WR_BIT:`HIC_MODE_RD_BIT])
    ) else $error("host mode write not taken");

    edge_needs_rise_a: assert property ( // RULE9
        (st.pending & ~$past(st.pending) & ~st.trig & ~$past(rise)) == `HIC_ZERO8
    ) else $error("edge bit set without a rising edge");

    level_not_latched_a: assert property ( // RULE7
        !wr_trig |=> (st.pending & st.trig & ~$past(lvl)) == `HIC_ZERO8
    ) else $error("level bit held after its source fell");

    clear_set_wins_a: assert property ( // RULE9
        wr_status && !wr_mask && !wr_trig
        |=> (st.pending & $past(rise & st.mask & ~st.trig)) == $past(rise & st.mask & ~st.trig)
    ) else $error("edge lost to a status write");

    raw_tracks_src_a: assert property ( // RULE4
        $past(reset_n_i) && $past(reset_n_i, 2) |-> lvl == $past(src_now, 2)
    ) else $error("raw level lags its source");

    settle_count_met_a: assert property ( // RULE11
        st.src.group_settled |-> $past(all_quiet)
            && st.settle_cnt > {1'b0, $past(settle_scan_count_i)}
    ) else $error("settled raised before the scan count");

    fault_sources_a: assert property ( // RULE13
        $past(reset_n_i) |-> st.src.fatal_tracking_fault == $past(|axis_fatal)
            && st.src.tracking_warning == $past(|axis_warn)
    ) else $error("following error source wrong");

    line_req_open_a: assert property ( // RULE12
        $past(reset_n_i) && !$past(buffer_open_i) |-> !st.src.program_line_request
    ) else $error("line request while no buffer open");

    ascii_pulse_a: assert property ( // RULE18
        auto_ascii && response_loaded_i |=> cmp_a
    ) else $error("response line gave no compare A pulse");

    host_char_off_a: assert property ( // RULE16
        $past(st.host_mode) == `HIC_MODE_RST |-> !st.src.host_char_request
    ) else $error("host char request while disabled");

endmodule : hic_ctrl
`default_nettype wire

// >>> verification/hic_host_model.sv
`default_nettype none
module hic_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output var hic_pkg::hic_host_bus_t host_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial host_o = '0;
    // Idle lines show the inverse of the last value so a stale address never passes
    task automatic idle();
        host_o.wr = 1'b0;
        host_o.rd = 1'b0;
        host_o.addr = ~host_o.addr;
        host_o.wdata = ~host_o.wdata;
    endtask : idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #10;
        host_o.addr = a;
        host_o.wdata = d;
        host_o.wr = 1'b1;
        @(posedge clk_i);
        #10;
        idle();
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #10;
        host_o.addr = a;
        host_o.rd = 1'b1;
        @(posedge clk_i);
        #10;
        d = rdata_i;
        idle();
    endtask : rd
endmodule : hic_host_model
`default_nettype wire

// >>> verification/tb_hic_ctrl.sv
`default_nettype none
module tb_hic_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, irq, tick, bopen, brot, rrdy, wrdy, awr, ast, astb, bwr, bst, bstb;
    logic aen, airq, resp, wd, ea, eb, e, tga, tgb;
    logic [7:0] rdata, ssc, v;
    logic [15:0] bfree, fthr, rthr, fullthr;
    logic [31:0] seed = 32'h000048E7;
    logic [31:0] r, r2;
    hic_pkg::hic_host_bus_t host;
    hic_pkg::hic_axis_t q;
    hic_pkg::hic_axis_t axes [8];
    int n_errors = 0;
    int tests_run = 0;

    hic_host_model host_m (.clk_i(clk), .rdata_i(rdata), .host_o(host));
    hic_ctrl dut (.clk_i(clk), .reset_n_i(rst_n), .host_i(host), .host_rdata_o(rdata),
        .host_irq_o(irq), .axes_i(axes), .scan_tick_i(tick), .settle_scan_count_i(ssc),
        .buffer_open_i(bopen), .buffer_is_rotary_i(brot), .buffer_free_i(bfree),
        .fixed_buffer_threshold_i(fthr), .rotary_ready_threshold_i(rthr),
        .rotary_full_threshold_i(fullthr), .host_read_ready_i(rrdy),
        .host_write_ready_i(wrdy), .fw_cmp_a_wr_i(awr), .compare_a_stage_value_i(ast),
        .compare_a_write_strobe_i(astb), .fw_cmp_b_wr_i(bwr),
        .compare_b_stage_value_i(bst), .compare_b_write_strobe_i(bstb),
        .match_toggle_a_i(tga), .match_toggle_b_i(tgb), .ascii_shared_mem_enable_i(aen),
        .ascii_shared_mem_irq_enable_i(airq), .response_loaded_i(resp),
        .watchdog_trip_i(wd));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : step
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic rchk(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
        logic [7:0] d;
        host_m.rd(a, d);
        chk(d & m, x & m);
    endtask : rchk
    task automatic set_axes();
        foreach (axes[i]) axes[i] = q;
    endtask : set_axes
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole sequence needs under 3000 cycles
    initial begin
        #(5000 * 100);
        n_errors++;
        end_sim();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst_n, tick, bopen, brot, rrdy, wrdy, awr, ast, astb, bwr, bst, bstb} = '0;
        {aen, airq, resp, wd, ea, eb, tga, tgb} = '0;
        {ssc, bfree, fthr, rthr, fullthr} = '0;
        q = '0;
        q.settle_band_limit = 16'h0001;
        q.fatal_error_limit = 16'hFFFF;
        q.warning_error_limit = 16'hFFFF;
        set_axes();
        repeat (5) @(posedge clk);
        #10 rst_n = 1'b1;
        rchk(4'hA, 8'h00);
        rchk(4'hB, 8'h00);
        rchk(4'h8, 8'h00);
        repeat (8) begin
            v = 8'(rnd());
            host_m.wr(4'hA, v);
            rchk(4'hA, v);
            v = 8'(rnd());
            host_m.wr(4'hB, v);
            rchk(4'hB, v);
        end
        host_m.wr(4'h5, 8'hFF);
        rchk(4'h5, 8'h00);
        host_m.wr(4'h9, 8'hFF);
        rchk(4'h9, 8'h00);
        host_m.wr(4'hA, 8'hFF);
        host_m.wr(4'hB, 8'h00);
        host_m.wr(4'h8, 8'h00);
        wd = 1'b1;
        step(6);
        chk({7'h0, irq}, 8'h01);
        rchk(4'h8, 8'h80);
        rchk(4'h9, 8'h80);
        host_m.wr(4'h8, 8'(rnd()));
        rchk(4'h8, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wd = 1'b0;
        step(6);
        rchk(4'h8, 8'h00);
        wd = 1'b1;
        step(6);
        rchk(4'h8, 8'h80);
        host_m.wr(4'hB, 8'h80);
        step(2);
        host_m.wr(4'h8, 8'h00);
        step(2);
        rchk(4'h8, 8'h80);
        wd = 1'b0;
        step(6);
        rchk(4'h8, 8'h00);
        host_m.wr(4'hA, 8'h7F);
        host_m.wr(4'hB, 8'h00);
        wd = 1'b1;
        step(6);
        rchk(4'h8, 8'h00);
        rchk(4'h9, 8'h80);
        wd = 1'b0;
        for (int m = 0; m < 4; m++) begin
            for (int rw = 0; rw < 4; rw++) begin
                host_m.wr(4'h0, 8'(m));
                rrdy = rw[0];
                wrdy = rw[1];
                e = (m[0] & rw[0]) | (m[1] & rw[1]);
                step(6);
                rchk(4'h9, {3'h0, e, 4'h0}, 8'h10);
            end
        end
        host_m.wr(4'h0, 8'h00);
        // Compare toggles land on bits 5 and 6
        {tga, tgb} = 2'h3;
        step(1);
        {tga, tgb} = 2'h0;
        {ea, eb} = 2'h3;
        step(6);
        rchk(4'h9, 8'h60, 8'h60);
        for (int i = 0; i < 9; i++) begin
            r = (i == 8) ? 32'h0000000C : rnd();
            {awr, ast, astb, bwr, bst, bstb} = {1'b1, r[0], r[2], 1'b1, r[1], r[3]};
            step(1);
            {awr, bwr} = 2'h0;
            ea = r[2] ? r[0] : ea;
            eb = r[3] ? r[1] : eb;
            step(6);
            rchk(4'h9, {1'b0, eb, ea, 5'h0}, 8'h60);
        end
        host_m.wr(4'hA, 8'h20);
        host_m.wr(4'h8, 8'h00);
        // With both ASCII options set, a loaded response line pulses compare A into status bit 5
        {aen, airq} = 2'h3;
        resp = 1'b1;
        step(1);
        resp = 1'b0;
        step(6);
        rchk(4'h8, 8'h20);
        {aen, airq} = 2'h0;
        repeat (8) begin
            // Earlier rounds must not leave a fault on another axis
            foreach (axes[i]) begin
                axes[i].fatal_error_limit = 16'hFFFF;
                axes[i].warning_error_limit = 16'hFFFF;
            end
            r = rnd();
            q.ferr_mag = r[15:0];
            q.fatal_error_limit = r[15:0] - {15'h0, r[16]};
            q.warning_error_limit = r[15:0] - {15'h0, r[17]};
            axes[r[20:18]] = q;
            step(6);
            rchk(4'h9, {4'h0, r[17] && r[15:0] != 0, r[16] && r[15:0] != 0, 2'h0},
                8'h0C);
        end
        q = '0;
        q.settle_band_limit = 16'h0001;
        q.fatal_error_limit = 16'hFFFF;
        q.warning_error_limit = 16'hFFFF;
        set_axes();
        repeat (8) begin
            r = rnd();
            r2 = rnd();
            {bopen, brot} = r[1:0];
            bfree = {12'h0, r[5:2]};
            fthr = {12'h0, r2[3:0]};
            rthr = {12'h0, r2[7:4]};
            fullthr = {12'h0, r2[11:8]};
            e = bopen & (brot ? (bfree >= rthr && bfree > fullthr) : bfree >= fthr);
            step(6);
            rchk(4'h9, {6'h0, e, 1'b0}, 8'h02);
        end
        for (int n = 0; n < 4; n += 3) begin
            ssc = 8'(n);
            set_axes();
            tick = 1'b1;
            step(1);
            tick = 1'b0;
            q.loop_closed = 1'b1;
            q.cmd_vel_zero = 1'b1;
            q.move_timer_idle = 1'b1;
            set_axes();
            for (int i = 1; i <= n + 1; i++) begin
                step(2);
                tick = 1'b1;
                step(1);
                tick = 1'b0;
                step(6);
                rchk(4'h9, {7'h0, i == n + 1}, 8'h01);
            end
            q.loop_closed = 1'b0;
        end
        host_m.wr(4'hB, 8'hFF);
        rst_n = 1'b0;
        step(5);
        rst_n = 1'b1;
        rchk(4'hB, 8'h00);
        end_sim();
    end
endmodule : tb_hic_ctrl
`default_nettype wire
